// ### rtl/port_pin_map.svh
/*
  Constants for the port line logic: register offsets, bit positions,
  reset values and masks. Included by port_pin_top, the checker and the testbench.
*/
`ifndef PORT_PIN_MAP_SVH
`define PORT_PIN_MAP_SVH

`define OFS_LATCH 16'hffc4
`define OFS_DIR 16'hffc6
`define OFS_ODRAIN 16'hf1c6
`define OFS_PULL_SEL 16'hfe7e
`define OFS_PULL_EN 16'hfe80
`define OFS_KEEP_EN 16'hfe82
`define OFS_CTRL 16'hfe90
`define OFS_STATUS 16'hfe94

`define LINE_MASK 16'hbfe8
`define PORT_RESET 16'h0000

`define BIT_TOGGLE_C 3
`define BIT_COUNT_D 5
`define BIT_COUNT_C 6
`define BIT_COUNT_B 7
`define BIT_SS_RX 8
`define BIT_SS_TX 9
`define BIT_AS_TX 10
`define BIT_AS_RX 11
`define BIT_BYTE_HI 12
`define BIT_SS_CLK 13
`define BIT_TOGGLE_F 15
`define BIT_SYSCLK 15

`define CTRL_PWRDN 0
`define CTRL_SYSCLK_EN 1
`define CTRL_STROBE_EN 2
`define CTRL_RESET 16'h0000

`endif

// ### rtl/port_pin_pkg.sv
/*
  Types for the port line logic.
  Assumes port_pin_map.svh is on the include path.
*/
`default_nettype none
package port_pin_pkg;
  typedef logic [15:0] port_word_t;
  typedef enum logic [1:0] {
    bus_idle,
    bus_wr,
    bus_rd
  } bus_phase_t;
endpackage
`default_nettype wire

// ### rtl/port_sync2.sv
/*
  Two-stage synchroniser for a vector of pin levels.
  Assumes the inputs are asynchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module port_sync2 #(
  parameter int W = 16
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### rtl/port_line_cell.sv
/*
  One port line: output mux with alternate AND gating, driver enable
  with power-down gating, and pull control.
  Assumes all inputs come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module port_line_cell (
  input wire logic latch_i,
  input wire logic dir_i,
  input wire logic odrain_i,
  input wire logic pull_en_i,
  input wire logic pull_sel_i,
  input wire logic keep_i,
  input wire logic pwrdn_i,
  input wire logic alt_out_i,
  input wire logic force_drive_i,
  output logic out_o,
  output logic oe_o,
  output logic pull_up_o,
  output logic pull_dn_o
);
  logic drive;
  logic level;

  always_comb
  begin
    level = latch_i & alt_out_i;
    drive = (dir_i | force_drive_i) & (~pwrdn_i | keep_i);
    if (odrain_i && level)
      drive = 1'b0;
    out_o = level;
    oe_o = drive;
    pull_up_o = ~(dir_i | force_drive_i) & pull_en_i & pull_sel_i;
    pull_dn_o = ~(dir_i | force_drive_i) & pull_en_i & ~pull_sel_i;
  end
endmodule
`default_nettype wire

// ### rtl/port_pin_top.sv
/*
  Port line block with shared peripheral functions and AHB-Lite registers.
  Assumes a single AHB-Lite master, word transfers, and asynchronous pins.
  // Function
  // - Keep-enable bits exist at 15, 13-5, 3
  // - Power-down drivers off unless keep bit set
  // - Alternate inputs read from input latch
  // - Three timer count inputs; D also up/down
  // - Alternate output ANDed with output latch
  // - Input direction floats; latch zero forces low
  // - Unused alternate output idles at one
  // - Output-only lines: timers, async tx, clock
  // - Bidirectional lines follow peripheral mode
  // - Clock output forces bit 15 driver
  // - Bit 3 toggle; bits 5-7 counts
  // - Bits 8, 9, 13 are sync serial
  // - Bit 10 async tx, bit 11 rx
  // - Bit 12 carries byte-high strobe
  // - Output lines keep pulls disabled
  // - Direction, drain, pull bits reset zero
*/
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.svh"
module port_pin_top
  import port_pin_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] pin_in_i,
  output logic [15:0] pin_out_o,
  output logic [15:0] pin_oe_o,
  output logic [15:0] pull_up_o,
  output logic [15:0] pull_dn_o,
  input wire logic timer_c_toggle_out_i,
  input wire logic timer_f_toggle_out_i,
  input wire logic async_serial_tx_out_i,
  input wire logic system_clock_out_i,
  input wire logic byte_high_enable_strobe_i,
  input wire logic sync_serial_master_rx_line_i,
  input wire logic sync_serial_master_tx_line_i,
  input wire logic sync_serial_clk_out_i,
  output logic timer_d_count_in_o,
  output logic timer_c_updown_ctl_o,
  output logic timer_b_updown_ctl_o,
  output logic timer_c_count_in_o,
  output logic timer_b_count_in_o,
  output logic sync_serial_master_rx_line_o,
  output logic sync_serial_master_tx_line_o,
  output logic sync_serial_clk_in_o,
  output logic async_serial_rx_in_o
);
  port_word_t port_output_latch_r;
  port_word_t line_direction_bits_r;
  port_word_t odrain_bits_r;
  port_word_t pull_enable_bits_r;
  port_word_t pull_select_bits_r;
  port_word_t powerdown_driver_keep_enable_r;
  port_word_t ctrl_r;
  port_word_t input_latch;
  port_word_t alt_out;
  port_word_t force_drive;
  port_word_t cell_out;
  port_word_t cell_oe;
  port_word_t cell_pu;
  port_word_t cell_pd;
  bus_phase_t phase_r;
  logic [15:0] addr_r;
  logic [15:0] wdata;
  logic [31:0] rdata_nxt;
  logic wr_en;

  // Input latch samples pins through two flip-flops
  port_sync2 #(
    .W(16)
  ) u_port_sync2 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .d_i(pin_in_i),
    .q_o(input_latch)
  );

  // Bus address phase capture
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      phase_r <= bus_idle;
      addr_r <= 16'h0000;
    end
    else if (hready)
    begin
      if (hsel && htrans[1])
      begin
        phase_r <= hwrite ? bus_wr : bus_rd;
        addr_r <= haddr[17:2];
      end
      else
        phase_r <= bus_idle;
    end
  end

  assign wdata = hwdata[15:0];
  assign wr_en = (phase_r == bus_wr);

  // Register writes in the data phase, one block per register
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      port_output_latch_r <= `PORT_RESET;
    else if (wr_en && addr_r == `OFS_LATCH)
      port_output_latch_r <= wdata & `LINE_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      line_direction_bits_r <= `PORT_RESET;
    else if (wr_en && addr_r == `OFS_DIR)
      line_direction_bits_r <= wdata & `LINE_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      odrain_bits_r <= `PORT_RESET;
    else if (wr_en && addr_r == `OFS_ODRAIN)
      odrain_bits_r <= wdata & `LINE_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pull_select_bits_r <= `PORT_RESET;
    else if (wr_en && addr_r == `OFS_PULL_SEL)
      pull_select_bits_r <= wdata & `LINE_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pull_enable_bits_r <= `PORT_RESET;
    else if (wr_en && addr_r == `OFS_PULL_EN)
      pull_enable_bits_r <= wdata & `LINE_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      powerdown_driver_keep_enable_r <= `PORT_RESET;
    else if (wr_en && addr_r == `OFS_KEEP_EN)
      powerdown_driver_keep_enable_r <= wdata & `LINE_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      ctrl_r <= `CTRL_RESET;
    else if (wr_en && addr_r == `OFS_CTRL)
      ctrl_r <= wdata & 16'h0007;
  end

  // Read mux, unmapped reads zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    case (haddr[17:2])
      `OFS_LATCH: rdata_nxt = {16'h0000, port_output_latch_r};
      `OFS_DIR: rdata_nxt = {16'h0000, line_direction_bits_r};
      `OFS_ODRAIN: rdata_nxt = {16'h0000, odrain_bits_r};
      `OFS_PULL_SEL: rdata_nxt = {16'h0000, pull_select_bits_r};
      `OFS_PULL_EN: rdata_nxt = {16'h0000, pull_enable_bits_r};
      `OFS_KEEP_EN: rdata_nxt = {16'h0000, powerdown_driver_keep_enable_r};
      `OFS_CTRL: rdata_nxt = {16'h0000, ctrl_r};
      `OFS_STATUS: rdata_nxt = {16'h0000, input_latch & `LINE_MASK};
      default: rdata_nxt = 32'h0000_0000;
    endcase
    // Write still in its data phase lands this edge; pass it on
    if (wr_en && addr_r == haddr[17:2])
    begin
      case (addr_r)
        `OFS_LATCH, `OFS_DIR, `OFS_ODRAIN, `OFS_PULL_SEL, `OFS_PULL_EN,
        `OFS_KEEP_EN: rdata_nxt = {16'h0000, wdata & `LINE_MASK};
        `OFS_CTRL: rdata_nxt = {16'h0000, wdata & 16'h0007};
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite)
      hrdata <= rdata_nxt;
  end

  // Zero-wait slave: always ready, always OKAY
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hreadyout <= 1'b1;
    else
      hreadyout <= 1'b1;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // Alternate outputs; idle level one when unused
  always_comb
  begin
    alt_out = 16'hffff;
    alt_out[`BIT_TOGGLE_C] = timer_c_toggle_out_i;
    alt_out[`BIT_SS_RX] = sync_serial_master_rx_line_i;
    alt_out[`BIT_SS_TX] = sync_serial_master_tx_line_i;
    alt_out[`BIT_AS_TX] = async_serial_tx_out_i;
    alt_out[`BIT_SS_CLK] = sync_serial_clk_out_i;
    if (ctrl_r[`CTRL_STROBE_EN])
      alt_out[`BIT_BYTE_HI] = byte_high_enable_strobe_i;
    if (ctrl_r[`CTRL_SYSCLK_EN])
      alt_out[`BIT_SYSCLK] = system_clock_out_i;
    else
      alt_out[`BIT_TOGGLE_F] = timer_f_toggle_out_i;
    force_drive = 16'h0000;
    force_drive[`BIT_SYSCLK] = ctrl_r[`CTRL_SYSCLK_EN];
    force_drive[`BIT_BYTE_HI] = ctrl_r[`CTRL_STROBE_EN];
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_line
      port_line_cell u_port_line_cell (
        .latch_i(port_output_latch_r[g]),
        .dir_i(line_direction_bits_r[g]),
        .odrain_i(odrain_bits_r[g]),
        .pull_en_i(pull_enable_bits_r[g]),
        .pull_sel_i(pull_select_bits_r[g]),
        .keep_i(powerdown_driver_keep_enable_r[g]),
        .pwrdn_i(ctrl_r[`CTRL_PWRDN]),
        .alt_out_i(alt_out[g]),
        .force_drive_i(force_drive[g]),
        .out_o(cell_out[g]),
        .oe_o(cell_oe[g]),
        .pull_up_o(cell_pu[g]),
        .pull_dn_o(cell_pd[g])
      );
    end
  endgenerate

  // Registered pin drive; AND gating, float on input lines not forced by clock or strobe
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pin_out_o <= 16'h0000;
    else
      pin_out_o <= cell_out & `LINE_MASK;
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      pin_oe_o <= 16'h0000;
    else
      pin_oe_o <= cell_oe & `LINE_MASK;
  end

  // Pulls only on lines that are not outputs
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pull_up_o <= 16'h0000;
      pull_dn_o <= 16'h0000;
    end
    else
    begin
      pull_up_o <= cell_pu & `LINE_MASK;
      pull_dn_o <= cell_pd & `LINE_MASK;
    end
  end

  // Alternate inputs taken from the input latch
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      timer_d_count_in_o <= 1'b0;
      timer_c_updown_ctl_o <= 1'b0;
      timer_b_updown_ctl_o <= 1'b0;
      timer_c_count_in_o <= 1'b0;
      timer_b_count_in_o <= 1'b0;
    end
    else
    begin
      timer_d_count_in_o <= input_latch[`BIT_COUNT_D];
      timer_c_updown_ctl_o <= input_latch[`BIT_COUNT_D];
      timer_b_updown_ctl_o <= input_latch[`BIT_COUNT_D];
      timer_c_count_in_o <= input_latch[`BIT_COUNT_C];
      timer_b_count_in_o <= input_latch[`BIT_COUNT_B];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_serial_master_rx_line_o <= 1'b0;
      sync_serial_master_tx_line_o <= 1'b0;
      sync_serial_clk_in_o <= 1'b0;
    end
    else
    begin
      sync_serial_master_rx_line_o <= input_latch[`BIT_SS_RX];
      sync_serial_master_tx_line_o <= input_latch[`BIT_SS_TX];
      sync_serial_clk_in_o <= input_latch[`BIT_SS_CLK];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
      async_serial_rx_in_o <= 1'b0;
    else
      async_serial_rx_in_o <= input_latch[`BIT_AS_RX];
  end
endmodule
`default_nettype wire

// ### bench/port_pin_props.sv
/*
  Checker on the pin side of port_pin_top.
  Assumes a bind into port_pin_top; sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.svh"
module port_pin_props (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] pin_in_i,
  input wire logic [15:0] pin_out_o,
  input wire logic [15:0] pin_oe_o,
  input wire logic [15:0] pull_up_o,
  input wire logic [15:0] pull_dn_o,
  input wire logic timer_c_toggle_out_i,
  input wire logic timer_d_count_in_o,
  input wire logic timer_c_updown_ctl_o,
  input wire logic timer_b_updown_ctl_o,
  input wire logic async_serial_rx_in_o
);
  logic [1:0] up_r;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  // Edges since reset, so the input pipe is full
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i)
      up_r <= 2'h0;
    else if (up_r != 2'h3)
      up_r <= up_r + 2'h1;
  property p_oe_mask; (pin_oe_o & ~`LINE_MASK) == 16'h0000; endproperty
  property p_out_mask; (pin_out_o & ~`LINE_MASK) == 16'h0000; endproperty
  property p_pull_off;
    ((pull_up_o | pull_dn_o) & pin_oe_o) == 16'h0000;
  endproperty
  property p_pull_one; (pull_up_o & pull_dn_o) == 16'h0000; endproperty
  property p_count_in;
    up_r == 2'h3 |-> timer_d_count_in_o == $past(pin_in_i[5], 3);
  endproperty
  property p_rx_in;
    up_r == 2'h3 |-> async_serial_rx_in_o == $past(pin_in_i[11], 3);
  endproperty
  property p_updown;
    timer_c_updown_ctl_o == timer_d_count_in_o &&
      timer_b_updown_ctl_o == timer_d_count_in_o;
  endproperty
  property p_and; pin_out_o[3] |-> $past(timer_c_toggle_out_i); endproperty
  a_oe_mask: assert property (p_oe_mask) else $error("oe mask");
  a_out_mask: assert property (p_out_mask) else $error("out mask");
  a_pull_off: assert property (p_pull_off) else $error("pull");
  a_pull_one: assert property (p_pull_one) else $error("pulls");
  a_count_in: assert property (p_count_in) else $error("count");
  a_rx_in: assert property (p_rx_in) else $error("rx in");
  a_updown: assert property (p_updown) else $error("updown");
  a_and: assert property (p_and) else $error("and");
  c_pull: cover property (pull_up_o != 16'h0000);
  c_pd: cover property (pin_oe_o == 16'h2008);
  c_cnt: cover property (timer_d_count_in_o);
endmodule
`default_nettype wire

// ### bench/port_pin_board.sv
/*
  Board model: resolves each pin's level from all drivers.
  Assumes the bench sets the external drive.
*/
`timescale 1ns/1ps
`default_nettype none
module port_pin_board (
  input wire logic core_clk_i,
  input wire logic [15:0] pin_out_i,
  input wire logic [15:0] pin_oe_i,
  input wire logic [15:0] pull_up_i,
  input wire logic [15:0] pull_dn_i,
  input wire logic [15:0] ext_val_i,
  input wire logic [15:0] ext_en_i,
  output logic [15:0] pin_in_o
);
  logic [15:0] flip_r = 16'h0000;
  // Floating lines wander every cycle
  always_ff @(posedge core_clk_i)
    flip_r <= ~flip_r;
  always_comb
    for (int i = 0; i < 16; i++)
      if (pin_oe_i[i])
        pin_in_o[i] = pin_out_i[i];
      else if (ext_en_i[i])
        pin_in_o[i] = ext_val_i[i];
      else if (pull_up_i[i] | pull_dn_i[i])
        pin_in_o[i] = pull_up_i[i];
      else
        pin_in_o[i] = flip_r[i];
endmodule
`default_nettype wire

// ### bench/port_pin_top_test.sv
/*
  Testbench for port_pin_top: AHB-Lite tasks, one task per scenario.
  Assumes the design, checker and board model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "port_pin_map.svh"
module port_pin_top_test;
  import port_pin_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic alt_r = 1'b1;
  logic strb_r = 1'b1;
  port_word_t ext_val = 16'h0000;
  port_word_t ext_en = 16'h0000;
  port_word_t pin_in_i, pin_out_o, pin_oe_o, pull_up_o, pull_dn_o;
  logic [31:0] hrdata;
  logic hreadyout, hresp, timer_d_count_in_o, timer_c_updown_ctl_o;
  logic timer_b_updown_ctl_o, timer_c_count_in_o, timer_b_count_in_o;
  logic sync_serial_master_rx_line_o, sync_serial_master_tx_line_o;
  logic sync_serial_clk_in_o, async_serial_rx_in_o;
  wire hready = hreadyout;
  wire timer_c_toggle_out_i = alt_r;
  wire timer_f_toggle_out_i = alt_r;
  wire async_serial_tx_out_i = alt_r;
  wire sync_serial_master_rx_line_i = alt_r;
  wire sync_serial_master_tx_line_i = alt_r;
  wire sync_serial_clk_out_i = alt_r;
  wire system_clock_out_i = strb_r;
  wire byte_high_enable_strobe_i = strb_r;
  int miscompares = 0;
  int check_count = 0;
  port_pin_top u_port_pin_top (.*);
  port_pin_board u_port_pin_board (.core_clk_i, .pin_out_i(pin_out_o),
    .pin_oe_i(pin_oe_o), .pull_up_i(pull_up_o), .pull_dn_i(pull_dn_o),
    .ext_val_i(ext_val), .ext_en_i(ext_en), .pin_in_o(pin_in_i));
  initial forever #12.5 core_clk_i = ~core_clk_i;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input port_word_t e, g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk_i);
      if (hreadyout === 1'b1)
        break;
    end
    if (n == 50)
    begin
      miscompares++;
      report_and_stop;
    end
  endtask
  task automatic bus(input logic w, input port_word_t a, d,
    output port_word_t q);
    @(posedge core_clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0000, a, 2'h0};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    wait_rdy;
    q = hrdata[15:0];
  endtask
  task automatic wr(input port_word_t a, d);
    port_word_t q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rchk(input string n, input port_word_t a, e);
    port_word_t q;
    bus(1'b0, a, 16'h0000, q);
    chk(n, e, q);
  endtask
  task automatic settle;
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask
  task automatic t_reset;
    rchk("keep", `OFS_KEEP_EN, 16'h0000);
    chk("oe", 16'h0000, pin_oe_o);
    rchk("dir", `OFS_DIR, 16'h0000);
    rchk("pull", `OFS_PULL_EN, 16'h0000);
    rchk("drain", `OFS_ODRAIN, 16'h0000);
  endtask
  task automatic t_keep;
    wr(`OFS_KEEP_EN, 16'hffff);
    rchk("keep", `OFS_KEEP_EN, 16'hbfe8);
    rchk("unmapped", 16'h0100, 16'h0000);
    chk("hresp", 16'h0000, {15'h0000, hresp});
    wr(`OFS_DIR, 16'hffff);
    wr(`OFS_LATCH, 16'hffff);
    wr(`OFS_KEEP_EN, 16'h2008);
    wr(`OFS_CTRL, 16'h0001);
    settle;
    chk("pd oe", 16'h2008, pin_oe_o);
    wr(`OFS_CTRL, 16'h0000);
    settle;
    chk("oe", 16'hbfe8, pin_oe_o);
  endtask
  task automatic t_alt;
    @(posedge core_clk_i);
    alt_r <= 1'b0;
    settle;
    chk("alt low", 16'h18e0, pin_out_o);
    @(posedge core_clk_i);
    alt_r <= 1'b1;
    settle;
    chk("alt idle", 16'hbfe8, pin_out_o);
    wr(`OFS_LATCH, 16'hfff7);
    settle;
    chk("latch low", 16'hbfe0, pin_out_o);
    wr(`OFS_DIR, 16'h0000);
    wr(`OFS_CTRL, 16'h0006);
    strb_r <= 1'b0;
    settle;
    chk("forced oe", 16'h9000, pin_oe_o);
    chk("strobe", 16'h2fe0, pin_out_o);
    @(posedge core_clk_i);
    strb_r <= 1'b1;
    wr(`OFS_CTRL, 16'h0000);
    settle;
    chk("input oe", 16'h0000, pin_oe_o);
  endtask
  task automatic t_pull;
    wr(`OFS_PULL_EN, 16'hffff);
    wr(`OFS_PULL_SEL, 16'h00f0);
    settle;
    chk("up", 16'h00e0, pull_up_o);
    chk("dn", 16'hbf08, pull_dn_o);
    wr(`OFS_DIR, 16'hff00);
    settle;
    chk("up out", 16'h00e0, pull_up_o);
    chk("dn out", 16'h0008, pull_dn_o);
    wr(`OFS_DIR, 16'h0000);
    wr(`OFS_PULL_EN, 16'h0000);
  endtask
  task automatic t_alt_in;
    port_word_t v;
    for (int k = 0; k < 2; k++)
    begin
      v = k ? 16'hd55f : 16'h2aa0;
      @(posedge core_clk_i);
      ext_en <= 16'hffff;
      ext_val <= v;
      settle;
      chk("alt in", {7'h00, v[5], v[5], v[5], v[6], v[7], v[8], v[9],
        v[11], v[13]}, {7'h00, timer_d_count_in_o, timer_c_updown_ctl_o,
        timer_b_updown_ctl_o, timer_c_count_in_o, timer_b_count_in_o,
        sync_serial_master_rx_line_o, sync_serial_master_tx_line_o,
        async_serial_rx_in_o, sync_serial_clk_in_o});
    end
  endtask
  task automatic t_odrain;
    wr(`OFS_DIR, 16'hffff);
    wr(`OFS_ODRAIN, 16'hffff);
    settle;
    chk("od oe", 16'h0008, pin_oe_o);
    wr(`OFS_LATCH, 16'h0000);
    settle;
    chk("od low", 16'hbfe8, pin_oe_o);
    chk("od out", 16'h0000, pin_out_o);
    wr(`OFS_ODRAIN, 16'h0000);
    wr(`OFS_DIR, 16'h0000);
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_keep;
    t_alt;
    t_pull;
    t_alt_in;
    t_odrain;
    report_and_stop;
  end
endmodule
bind port_pin_top port_pin_props u_port_pin_props (.core_clk_i, .rst_i,
  .pin_in_i, .pin_out_o, .pin_oe_o, .pull_up_o, .pull_dn_o,
  .timer_c_toggle_out_i, .timer_d_count_in_o, .timer_c_updown_ctl_o,
  .timer_b_updown_ctl_o, .async_serial_rx_in_o);
`default_nettype wire
